// ===== design/lcd_palette_dither_shifter.sv
/*
 * Pixel path of the panel controller: input buffer, palette lookup, STN
 * frame-rate-control dithering and the shifter that packs the panel data bus.
 * Assumes a timing generator that pulses line_start and frame_start and
 * stalls the output with panel_ready, and an upstream pixel source.
 */
// Function
// - Palette used for TFT 1-8 bpp, mono 1-2, colour 1-8; bypassed otherwise.
// - Host reads and writes every entry; low 16 data bits stored, upper ignored.
// - Palette holds 256 programmable 16-bit entries, indexed by pixel value.
// - Entry layout: intensity, blue, green, red from top bit down.
// - STN mono with palette (1-2 bpp) uses upper four red bits as 16-level gray.
// - STN colour uses upper four bits of blue, green and red.
// - TFT palette mode drives all colour bits, intensity at bits 18, 10, 2.
// - TFT palette mode holds bits 17:16, 9:8 and 1:0 at zero.
// - STN shades come from frame rate control varying per frame and position.
// - Gray levels 15..0 map to the listed duty cycles, 15 on, 0 off.
// - Paired levels share one pattern; levels 1 to 7 use its inverse.
// - Pixel at 4n+m is on when pattern bit 3-m is set.
// - Each frame takes the next 4-bit pattern, wrapping after the last.
// - Colour sub-pixels dithered separately by their bus position, top bit first.
// - Each dual scan half is dithered and packed like single scan.
// - One pixel or three sub-pixels per step, packed to the interface width.
// - Display type selects TFT, STN mono or STN colour behaviour.
// - Scan mode selects single or dual; TFT is always single scan.
// - STN bus width is 4 (single), 8, or 16 (dual) bits.
// - Palette index is the low 1, 2, 4 or 8 pixel bits.
`timescale 1ns/1ps
module lcd_palette_dither_shifter
    import lcd_pix_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Configuration.
    input wire logic [1:0] display_type_select,
    input wire logic [2:0] bits_per_pixel_select,
    input wire logic scan_mode_select,
    input wire logic [1:0] interface_width_select,
    // Dither pattern sequences, first pattern in the top nibble.
    input wire logic [27:0] pattern_six_sevenths,
    input wire logic [19:0] pattern_four_fifths,
    input wire logic [15:0] pattern_three_quarters,
    input wire logic [27:0] pattern_five_sevenths,
    input wire logic [11:0] pattern_two_thirds,
    input wire logic [19:0] pattern_three_fifths,
    input wire logic [27:0] pattern_four_sevenths,
    input wire logic [7:0] pattern_one_half,
    // Host palette access.
    input wire logic pal_wr_en,
    input wire logic pal_rd_en,
    input wire logic [7:0] pal_addr,
    input wire logic [31:0] pal_wdata,
    output logic [31:0] pal_rdata,
    output logic pal_rd_valid,
    // Timing generator strobes.
    input wire logic frame_start,
    input wire logic line_start,
    // Upstream pixels; lower half only used in dual scan.
    input wire logic pix_valid,
    output logic pix_ready,
    input wire logic [PIX_WIDTH-1:0] pix_upper,
    input wire logic [PIX_WIDTH-1:0] pix_lower,
    // Panel side.
    output logic [BUS_WIDTH-1:0] panel_data_bus,
    output logic panel_data_valid,
    input wire logic panel_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Input buffer.

    logic buf_valid, buf_ready;
    logic [2*PIX_WIDTH-1:0] buf_data;

    pixel_fifo #(
        .WIDTH(2*PIX_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(pix_valid),
        .in_ready(pix_ready),
        .in_data({pix_upper, pix_lower}),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Palette storage and host port.

    logic [PAL_WIDTH-1:0] pal_q [PAL_DEPTH];
    logic [PAL_WIDTH-1:0] pal_d [PAL_DEPTH];
    logic [31:0] rdata_q, rdata_d;
    logic rd_valid_q, rd_valid_d;

    always_comb begin
        pal_d = pal_q;
        if (pal_wr_en) begin
            pal_d[pal_addr] = pal_wdata[PAL_WIDTH-1:0];
        end
        rd_valid_d = pal_rd_en;
        rdata_d = pal_rd_en ? {16'h0000, pal_q[pal_addr]} : rdata_q;
    end

    always_ff @(posedge clk) begin
        pal_q <= pal_d;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            rd_valid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign pal_rdata = rdata_q;
    assign pal_rd_valid = rd_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Frame pattern counters, one per sequence length.

    logic [2:0] f7_q, f5_q, f4_q, f3_q, f2_q;
    logic [2:0] f7_d, f5_d, f4_d, f3_d, f2_d;

    function automatic logic [2:0] wrap_inc(input logic [2:0] v, input logic [2:0] len);
        return (v == len - 3'h1) ? 3'h0 : v + 3'h1;
    endfunction

    always_comb begin
        f7_d = f7_q;
        f5_d = f5_q;
        f4_d = f4_q;
        f3_d = f3_q;
        f2_d = f2_q;
        if (frame_start) begin
            f7_d = wrap_inc(f7_q, SEVENTHS_LEN);
            f5_d = wrap_inc(f5_q, FIFTHS_LEN);
            f4_d = wrap_inc(f4_q, QUARTERS_LEN);
            f3_d = wrap_inc(f3_q, THIRDS_LEN);
            f2_d = wrap_inc(f2_q, HALVES_LEN);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            f7_q <= FRAME_IDX_RESET;
            f5_q <= FRAME_IDX_RESET;
            f4_q <= FRAME_IDX_RESET;
            f3_q <= FRAME_IDX_RESET;
            f2_q <= FRAME_IDX_RESET;
        end else begin
            f7_q <= f7_d;
            f5_q <= f5_d;
            f4_q <= f4_d;
            f3_q <= f3_d;
            f2_q <= f2_d;
        end
    end

    // Picks pattern idx from a sequence left-aligned in 28 bits.
    function automatic logic [3:0] pick(input logic [27:0] seq, input logic [2:0] idx);
        return seq[27 - 4 * int'(idx) -: 4];
    endfunction

    logic [3:0] p67, p45, p34, p57, p23, p35, p47, p12;

    assign p67 = pick(pattern_six_sevenths, f7_q);
    assign p45 = pick({pattern_four_fifths, 8'h00}, f5_q);
    assign p34 = pick({pattern_three_quarters, 12'h000}, f4_q);
    assign p57 = pick(pattern_five_sevenths, f7_q);
    assign p23 = pick({pattern_two_thirds, 16'h0000}, f3_q);
    assign p35 = pick({pattern_three_fifths, 8'h00}, f5_q);
    assign p47 = pick(pattern_four_sevenths, f7_q);
    assign p12 = pick({pattern_one_half, 20'h00000}, f2_q);

    // On/off decision for one gray level at a horizontal position.
    function automatic logic dither(input logic [3:0] level, input logic [1:0] m);
        logic [3:0] pat;
        pat = 4'h0;
        case (level)
            4'hF: pat = 4'hF;
            4'hE: pat = p67;
            4'hD: pat = p45;
            4'hC: pat = p34;
            4'hB: pat = p57;
            4'hA: pat = p23;
            4'h9: pat = p35;
            4'h8: pat = p47;
            4'h7: pat = ~p12;
            4'h6: pat = ~p47;
            4'h5: pat = ~p35;
            4'h4: pat = ~p23;
            4'h3: pat = ~p34;
            4'h2: pat = ~p45;
            4'h1: pat = ~p67;
            default: pat = 4'h0;
        endcase
        return pat[2'h3 - m];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode.

    logic is_tft, is_mono, is_color, use_pal, dual;
    logic [3:0] half_w;
    logic [7:0] idx_mask;

    always_comb begin
        is_tft = (display_type_select == DISP_TFT);
        is_mono = (display_type_select == DISP_STN_MONO);
        is_color = (display_type_select == DISP_STN_COLOR);
        use_pal = (is_mono && bits_per_pixel_select <= BPP_2)
               || (!is_mono && bits_per_pixel_select <= BPP_8);
        dual = !is_tft && (scan_mode_select == SCAN_DUAL);
        case (interface_width_select)
            IFW_4: half_w = 4'h4;
            IFW_8: half_w = dual ? 4'h4 : 4'h8;
            IFW_16: half_w = 4'h8;
            default: half_w = 4'h8;
        endcase
        case (bits_per_pixel_select)
            BPP_1: idx_mask = 8'h01;
            BPP_2: idx_mask = 8'h03;
            BPP_4: idx_mask = 8'h0F;
            default: idx_mask = 8'hFF;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lookup, dithering and packing.

    logic [15:0] acc_q [2];
    logic [15:0] acc_d [2];
    logic [4:0] cnt_q [2];
    logic [4:0] cnt_d [2];
    logic [1:0] pos_q, pos_d;
    logic [BUS_WIDTH-1:0] out_q, out_d;
    logic out_valid_q, out_valid_d;
    logic take;

    assign buf_ready = !out_valid_q || panel_ready;
    assign take = buf_valid && buf_ready;

    always_comb begin
        logic [PIX_WIDTH-1:0] pix;
        logic [15:0] entry;
        logic [2:0] bits;
        logic [1:0] n;
        logic [15:0] acc;
        logic [4:0] cnt;
        logic [7:0] word [2];
        logic emit;
        pix = '0;
        entry = '0;
        bits = '0;
        acc = '0;
        cnt = '0;
        word[0] = '0;
        word[1] = '0;
        emit = 1'b0;
        n = is_color ? 2'h3 : 2'h1;
        out_d = out_q;
        out_valid_d = out_valid_q && !panel_ready;
        pos_d = line_start ? 2'h0 : pos_q;
        for (int h = 0; h < 2; h++) begin
            acc_d[h] = line_start ? 16'h0000 : acc_q[h];
            cnt_d[h] = line_start ? 5'h00 : cnt_q[h];
        end
        if (take) begin
            for (int h = 0; h < 2; h++) begin
                pix = (h == 0) ? buf_data[2*PIX_WIDTH-1:PIX_WIDTH] : buf_data[PIX_WIDTH-1:0];
                entry = use_pal ? pal_q[pix[7:0] & idx_mask] : pix[15:0];
                if (is_mono) begin
                    // Non-palette mono pixels carry the gray level directly.
                    bits[0] = dither(use_pal ? entry[RED_LSB+4 -: 4] : pix[3:0],
                        pos_d);
                    bits[2:1] = 2'h0;
                end else begin
                    bits[2] = dither(entry[RED_LSB+4 -: 4], pos_d);
                    bits[1] = dither(entry[GREEN_LSB+4 -: 4], pos_d + 2'h1);
                    bits[0] = dither(entry[BLUE_LSB+4 -: 4], pos_d + 2'h2);
                end
                acc = (acc_d[h] << n) | (is_color ? 16'(bits) : 16'(bits[0]));
                cnt = cnt_d[h] + 5'(n);
                emit = (cnt >= 5'(half_w));
                if (emit) begin
                    word[h] = 8'(acc >> (cnt - 5'(half_w)))
                        & ((half_w == 4'h4) ? 8'h0F : 8'hFF);
                    cnt = cnt - 5'(half_w);
                end
                acc_d[h] = acc;
                cnt_d[h] = cnt;
            end
            pos_d = pos_d + n;
            if (is_tft) begin
                pix = buf_data[2*PIX_WIDTH-1:PIX_WIDTH];
                entry = use_pal ? pal_q[pix[7:0] & idx_mask] : pix[15:0];
                // Blue, green, red bytes each take 5 colour bits and intensity.
                out_d = (bits_per_pixel_select == BPP_24) ? pix
                    : {entry[BLUE_LSB+4 -: 5], entry[INTENSITY_POS], 2'h0,
                       entry[GREEN_LSB+4 -: 5], entry[INTENSITY_POS], 2'h0,
                       entry[RED_LSB+4 -: 5], entry[INTENSITY_POS], 2'h0};
                out_valid_d = 1'b1;
            end else if (emit) begin
                // Upper half takes the top lane of the bus in dual scan.
                out_d = dual ? 24'((16'(word[0]) << half_w) | 16'(word[1]))
                    : 24'(word[0]);
                out_valid_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q[0] <= 16'h0000;
            acc_q[1] <= 16'h0000;
            cnt_q[0] <= 5'h00;
            cnt_q[1] <= 5'h00;
            pos_q <= 2'h0;
            out_q <= 24'h000000;
            out_valid_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            pos_q <= pos_d;
            out_q <= out_d;
            out_valid_q <= out_valid_d;
        end
    end

    assign panel_data_bus = out_q;
    assign panel_data_valid = out_valid_q;

endmodule

// ===== design/lcd_pix_pkg.sv
/*
 * Constants shared by the pixel path of the panel controller: encodings of
 * the configuration selects, palette entry layout, dither sequence lengths
 * and buffer sizes. Assumes nothing of its surroundings.
 */
package lcd_pix_pkg;

    // Display type encodings.
    localparam logic [1:0] DISP_STN_MONO = 2'h0;
    localparam logic [1:0] DISP_STN_COLOR = 2'h1;
    localparam logic [1:0] DISP_TFT = 2'h2;

    // Bits per pixel encodings.
    localparam logic [2:0] BPP_1 = 3'h0;
    localparam logic [2:0] BPP_2 = 3'h1;
    localparam logic [2:0] BPP_4 = 3'h2;
    localparam logic [2:0] BPP_8 = 3'h3;
    localparam logic [2:0] BPP_16 = 3'h4;
    localparam logic [2:0] BPP_24 = 3'h5;

    // Scan mode and STN interface width encodings.
    localparam logic SCAN_SINGLE = 1'b0;
    localparam logic SCAN_DUAL = 1'b1;
    localparam logic [1:0] IFW_4 = 2'h0;
    localparam logic [1:0] IFW_8 = 2'h1;
    localparam logic [1:0] IFW_16 = 2'h2;

    // Palette geometry and entry layout.
    localparam int PAL_DEPTH = 256;
    localparam int PAL_WIDTH = 16;
    localparam int RED_LSB = 0;
    localparam int GREEN_LSB = 5;
    localparam int BLUE_LSB = 10;
    localparam int INTENSITY_POS = 15;

    // Dither sequence lengths in 4-bit patterns.
    localparam logic [2:0] SEVENTHS_LEN = 3'h7;
    localparam logic [2:0] FIFTHS_LEN = 3'h5;
    localparam logic [2:0] QUARTERS_LEN = 3'h4;
    localparam logic [2:0] THIRDS_LEN = 3'h3;
    localparam logic [2:0] HALVES_LEN = 3'h2;
    localparam logic [2:0] FRAME_IDX_RESET = 3'h0;

    // Pixel path sizes.
    localparam int PIX_WIDTH = 24;
    localparam int FIFO_DEPTH = 8;
    localparam int BUS_WIDTH = 24;

endpackage

// ===== design/pixel_fifo.sv
/*
 * Synchronous FIFO with valid/ready handshakes on both sides, storage in
 * flip-flops. Assumes a single clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module pixel_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            mem_d[wr_q] = in_data;
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        mem_q <= mem_d;
    end

endmodule

// ===== sim/lcd_palette_dither_shifter_sva.sv
/* Concurrent checks on the ports of the panel pixel path.
   Assumes one clock, an active-low asynchronous reset and the package encodings. */
`timescale 1ns/1ps
module lcd_pds_checker
    import lcd_pix_pkg::*;
(
    // Clock, reset and configuration.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] display_type_select,
    input wire logic [2:0] bits_per_pixel_select,
    // Host palette access.
    input wire logic pal_wr_en,
    input wire logic pal_rd_en,
    input wire logic [7:0] pal_addr,
    input wire logic [31:0] pal_wdata,
    input wire logic [31:0] pal_rdata,
    input wire logic pal_rd_valid,
    // Pixel stream and panel side.
    input wire logic pix_ready,
    input wire logic [BUS_WIDTH-1:0] panel_data_bus,
    input wire logic panel_data_valid,
    input wire logic panel_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic tft_pal;
    assign tft_pal = display_type_select == DISP_TFT && bits_per_pixel_select <= BPP_8
        && panel_data_valid;
    ////////////////////////////////////////////////////////////////
    sequence s_write_then_read;
        pal_wr_en && !pal_rd_en ##1 pal_rd_en && pal_addr == $past(pal_addr);
    endsequence
    property p_rd_answer;
        pal_rd_en |=> pal_rd_valid && pal_rdata[31:16] == 16'h0000;
    endproperty
    property p_rd_quiet;
        !pal_rd_en |=> !pal_rd_valid && $stable(pal_rdata);
    endproperty
    property p_write_read;
        s_write_then_read |=> pal_rdata[15:0] == $past(pal_wdata[15:0], 2);
    endproperty
    property p_hold;
        panel_data_valid && !panel_ready |=> panel_data_valid && $stable(panel_data_bus);
    endproperty
    property p_tft_zero;
        tft_pal |-> panel_data_bus[17:16] == 2'h0 && panel_data_bus[9:8] == 2'h0
            && panel_data_bus[1:0] == 2'h0;
    endproperty
    property p_tft_intensity;
        tft_pal |-> panel_data_bus[18] == panel_data_bus[10]
            && panel_data_bus[10] == panel_data_bus[2];
    endproperty
    property p_full_drains;
        !pix_ready && panel_ready |-> ##[1:4] pix_ready;
    endproperty
    property p_full_stalls;
        !pix_ready && panel_data_valid && !panel_ready |=> !pix_ready;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data moved unasked");
    a_write_read: assert property (p_write_read) else $error("entry not kept");
    a_hold: assert property (p_hold) else $error("word changed while stalled");
    a_tft_zero: assert property (p_tft_zero) else $error("unused bit set");
    a_tft_intensity: assert property (p_tft_intensity) else $error("intensity split");
    a_full_drains: assert property (p_full_drains) else $error("buffer never drains");
    a_full_stalls: assert property (p_full_stalls) else $error("buffer leaked");
endmodule

bind lcd_palette_dither_shifter lcd_pds_checker i_checker (
    .clk(clk), .rst_n(rst_n), .display_type_select(display_type_select),
    .bits_per_pixel_select(bits_per_pixel_select), .pal_wr_en(pal_wr_en),
    .pal_rd_en(pal_rd_en), .pal_addr(pal_addr), .pal_wdata(pal_wdata), .pal_rdata(pal_rdata),
    .pal_rd_valid(pal_rd_valid), .pix_ready(pix_ready), .panel_data_bus(panel_data_bus),
    .panel_data_valid(panel_data_valid), .panel_ready(panel_ready));

// ===== sim/panel_model.sv
/* Panel-side model: takes packed words under a chosen pacing, in order.
   Assumes the bench reads and clears the words queue between tests. */
`timescale 1ns/1ps
module panel_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Pacing: 0 prompt, 1 every other cycle, 2 stalled.
    input wire logic [1:0] mode,
    // Panel data side.
    input wire logic [23:0] panel_data_bus,
    input wire logic panel_data_valid,
    output logic panel_ready
);
    logic [23:0] words[$];
    logic toggle_q;
    assign panel_ready = mode == 2'h0 || (mode == 2'h1 && toggle_q);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            toggle_q <= 1'h0;
        end else begin
            toggle_q <= ~toggle_q;
            if (panel_data_valid && panel_ready) begin
                words.push_back(panel_data_bus);
            end
        end
    end
endmodule

// ===== sim/test_lcd_palette_dither_shifter.sv
/* Self-checking bench for the panel pixel path: palette, TFT formatting,
   STN dithering and packing, buffer back-pressure.
   Assumes panel_model on the panel side and the package encodings. */
`timescale 1ns/1ps
module test_lcd_palette_dither_shifter
    import lcd_pix_pkg::*;
;
    localparam logic [15:0] CE = {1'h1, 4'hE, 1'h1, 4'h9, 1'h1, 4'hA, 1'h1};
    logic [27:0] p67 = 28'hEFDB7BE, p57 = 28'hDA6B5E9, p47 = 28'h96A5C3A;
    logic [19:0] p45 = 20'hDEB7E, p35 = 20'hA5A5F;
    logic [15:0] p34 = 16'hE7BD;
    logic [11:0] p23 = 12'hDB6;
    logic [7:0] p12 = 8'h69, addr = 8'h00;
    logic clk = 1'h0, rst_n = 1'h0, scan = SCAN_SINGLE, wr = 1'h0, rd = 1'h0;
    logic fs = 1'h0, ls = 1'h0, pv = 1'h0, rvalid, pready, dvalid, panel_ready;
    logic [1:0] dtype = DISP_TFT, ifw = IFW_4, mode = 2'h0;
    logic [2:0] bpp = BPP_8;
    logic [31:0] wdata = 32'h0, rdata;
    logic [23:0] up = 24'h0, lo = 24'h0, bus;
    logic [23:0] exp_q[$];
    logic [39:0] pal_init[4] = '{40'hFF_FFFF_FFFF, 40'h00_FFFF_8421, 40'h01_0000_5AA5,
        {8'h3C, 16'hABCD, CE}};
    int kmap[16] = '{0, 14, 13, 12, 10, 9, 8, 7, 8, 9, 10, 11, 12, 13, 14, 15};
    int lens[7:14] = '{2, 7, 5, 3, 7, 4, 5, 7};
    int failures = 0, comparisons = 0, fc = 0;

    lcd_palette_dither_shifter i_dut (.clk(clk), .rst_n(rst_n), .display_type_select(dtype),
        .bits_per_pixel_select(bpp), .scan_mode_select(scan), .interface_width_select(ifw),
        .pattern_six_sevenths(p67), .pattern_four_fifths(p45), .pattern_three_quarters(p34),
        .pattern_five_sevenths(p57), .pattern_two_thirds(p23), .pattern_three_fifths(p35),
        .pattern_four_sevenths(p47), .pattern_one_half(p12), .pal_wr_en(wr), .pal_rd_en(rd),
        .pal_addr(addr), .pal_wdata(wdata), .pal_rdata(rdata), .pal_rd_valid(rvalid),
        .frame_start(fs), .line_start(ls), .pix_valid(pv), .pix_ready(pready),
        .pix_upper(up), .pix_lower(lo), .panel_data_bus(bus), .panel_data_valid(dvalid),
        .panel_ready(panel_ready));
    panel_model i_panel (.clk(clk), .rst_n(rst_n), .mode(mode), .panel_data_bus(bus),
        .panel_data_valid(dvalid), .panel_ready(panel_ready));

    always #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    // Pattern nibble for a gray level in the current frame; levels 1 to 7 invert.
    function automatic logic [3:0] nib(input int lvl);
        int k;
        logic [27:0] s;
        k = kmap[lvl];
        case (k)
            0: return 4'h0;
            15: return 4'hF;
            7: s = 28'(p12);
            8: s = p47;
            9: s = 28'(p35);
            10: s = 28'(p23);
            11: s = p57;
            12: s = 28'(p34);
            13: s = 28'(p45);
            default: s = p67;
        endcase
        s = s >> (4 * (lens[k] - 1 - fc % lens[k]));
        return lvl < 8 ? ~s[3:0] : s[3:0];
    endfunction
    function automatic logic [23:0] tft(input logic [15:0] e);
        return {e[14:10], e[15], 2'h0, e[9:5], e[15], 2'h0, e[4:0], e[15], 2'h0};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #10;
    endtask
    task automatic pal(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        wr = w;
        rd = r;
        addr = a;
        wdata = d;
        step();
    endtask
    task automatic push(input logic [23:0] u, input logic [23:0] l);
        int n;
        n = 0;
        pv = 1'h1;
        up = u;
        lo = l;
        while (!pready && n < 100) begin
            step();
            n++;
        end
        step();
    endtask
    task automatic pushx(input logic [23:0] u, input logic [23:0] want);
        push(u, ~u);
        exp_q.push_back(want);
    endtask
    task automatic strobe(input logic f);
        fs = f;
        ls = 1'h1;
        fc += f;
        step();
        fs = 1'h0;
        ls = 1'h0;
    endtask
    task automatic done(input logic [23:0] mask, input string name);
        int n;
        n = 0;
        pv = 1'h0;
        while (i_panel.words.size() < exp_q.size() && n < 500) begin
            step();
            n++;
        end
        repeat (4) step();
        check(i_panel.words.size(), exp_q.size());
        foreach (exp_q[j]) check(i_panel.words[j] & mask, exp_q[j]);
        $display("test %s done", name);
        i_panel.words.delete();
        exp_q.delete();
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] st;
        logic [3:0] n4;
        int n;
        repeat (6) @(posedge clk);
        #10;
        rst_n = 1'h1;
        foreach (pal_init[j]) begin
            pal(1'h1, 1'h0, pal_init[j][39:32], pal_init[j][31:0]);
            pal(1'h0, 1'h1, pal_init[j][39:32], 32'h0);
            check(rvalid, 1'h1);
            check(rdata, {16'h0000, pal_init[j][15:0]});
        end
        pal(1'h0, 1'h0, 8'h00, 32'h0);
        $display("test palette done");
        scan = SCAN_DUAL;
        bpp = BPP_1;
        pushx(24'hFFFFFE, tft(16'h8421));
        pushx(24'h000003, tft(16'h5AA5));
        done(24'hFFFFFF, "tft 1bpp");
        bpp = BPP_8;
        pushx(24'hABCDFF, tft(16'hFFFF));
        pushx(24'h123400, tft(16'h8421));
        done(24'hFFFFFF, "tft 8bpp");
        bpp = BPP_16;
        pushx(24'hFF5AA5, tft(16'h5AA5));
        done(24'hFFFFFF, "tft 16bpp");
        bpp = BPP_24;
        pushx(24'h123456, 24'h123456);
        done(24'hFFFFFF, "tft 24bpp");
        dtype = DISP_STN_MONO;
        bpp = BPP_4;
        scan = SCAN_SINGLE;
        mode = 2'h1;
        for (int f = 0; f < 8; f++) begin
            strobe(f != 0);
            for (int l = 0; l < 16; l++) begin
                repeat (4) push({20'hFFFFF, l[3:0]}, 24'h0);
                exp_q.push_back({20'h0, nib(l)});
            end
            done(24'h00000F, "mono frame");
        end
        bpp = BPP_1;
        strobe(1'h0);
        repeat (4) push(24'h000001, 24'h0);
        repeat (4) push(24'h000000, 24'h0);
        exp_q.push_back({20'h0, nib(2)});
        exp_q.push_back(24'h0);
        done(24'h00000F, "mono palette");
        rst_n = 1'h0;
        repeat (6) step();
        rst_n = 1'h1;
        fc = 0;
        check(dvalid, 1'h0);
        dtype = DISP_STN_COLOR;
        bpp = BPP_8;
        ifw = IFW_8;
        mode = 2'h0;
        for (int f = 0; f < 3; f++) begin
            strobe(f != 0);
            repeat (8) push(24'hFFFF3C, 24'h0);
            for (int b = 0; b < 24; b++) begin
                n4 = nib(b % 3 == 0 ? 10 : b % 3 == 1 ? 9 : 14);
                st[23 - b] = n4[3 - b % 4];
            end
            for (int w = 0; w < 3; w++) exp_q.push_back({16'h0, st[23 - 8 * w -: 8]});
            done(24'h0000FF, "colour frame");
        end
        dtype = DISP_STN_MONO;
        bpp = BPP_4;
        scan = SCAN_DUAL;
        strobe(1'h0);
        repeat (4) push(24'h000009, 24'h000005);
        exp_q.push_back({16'h0, nib(9), nib(5)});
        done(24'h0000FF, "dual 8");
        ifw = IFW_16;
        strobe(1'h0);
        repeat (8) push(24'h00000C, 24'h000003);
        exp_q.push_back({8'h0, nib(12), nib(12), nib(3), nib(3)});
        done(24'h00FFFF, "dual 16");
        dtype = DISP_TFT;
        bpp = BPP_24;
        scan = SCAN_SINGLE;
        mode = 2'h2;
        n = 0;
        pv = 1'h1;
        for (int i = 0; i < 12; i++) begin
            up = 24'h00A000 + 24'(i);
            if (!pready) break;
            exp_q.push_back(up);
            step();
            n++;
        end
        pv = 1'h0;
        repeat (3) step();
        check(pready, 1'h0);
        check(n, FIFO_DEPTH + 1);
        mode = 2'h0;
        done(24'hFFFFFF, "fill");
        wrap_up();
    end
    initial begin
        #(30000 * 100);
        failures++;
        $display("unexpected at %0t: run did not finish", $time);
        wrap_up();
    end
endmodule
